// ==== logic/adcri_pkg.sv ====
// package: register map, field layout and types of the converter
// result and interrupt block
// assumes a 32-bit bus slave decoding the low eight address bits
// Functional notes
// - done flag set on finish, read clears
// - done flag reads one only if enabled
// - last result latched, held till next
// - enable-set write ones set mask
// - enable-clear write ones clear mask
// - mask readable, same layout as flags
// - channel result loads only when enabled
// - channel result holds until newer conversion
// - read-only revision number in low bits
// - variant number read in bits 16 to 19 beside the revision
// - eight channels, each flags and result
// - triggers zero to five from timers
// - data ready set on result, read clears
// - overrun flags cleared by flag read
// - trigger codes select internal or external
// - only enabled channels report done flags; overrun flags and channel results read regardless of enable
package adcri_pkg;

    localparam int DATA_W  = 10;
    localparam int FLAG_W  = 20;
    localparam int REV_W   = 12;
    localparam int VAR_W   = 4;
    localparam int VAR_LO  = 16;

    localparam logic [7:0] OFF_FLAG = 8'h1C;
    localparam logic [7:0] OFF_LAST = 8'h20;
    localparam logic [7:0] OFF_IEN  = 8'h24;
    localparam logic [7:0] OFF_IDIS = 8'h28;
    localparam logic [7:0] OFF_MASK = 8'h2C;
    localparam logic [7:0] OFF_CH0  = 8'h30;
    localparam logic [7:0] OFF_REV  = 8'hFC;

    localparam int BIT_OVR_LO = 8;
    localparam int BIT_RESULT_AVAILABLE_FLAG   = 16;
    localparam int BIT_GOVR   = 17;
    localparam int BIT_DMA_RECEIVE_END_FLAG  = 18;
    localparam int BIT_RXBF   = 19;

    localparam logic [31:0] FLAG_RST  = 32'h000C_0000;
    localparam logic [31:0] MASK_RST  = 32'h0000_0000;
    localparam logic [2:0]  TRIG_LAST = 3'h5;
    localparam logic [2:0]  TRIG_EXT  = 3'h6;

    typedef struct packed {
        logic              done;
        logic [2:0]        chan;
        logic [DATA_W-1:0] data;
    } adcri_conv_t;

endpackage

// ==== logic/adcri_top.sv ====
// file: converter result registers, flags, mask and trigger mux
// assumes an AHB-Lite master, one-cycle done pulses from the core
// and channel enables held by the control block
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
module adcri_top
    import adcri_pkg::*;
#(
    parameter int          NCH      = 8,
    // arbitrary neutral values
    parameter logic [11:0] REVISION = 12'h0A5,
    parameter logic [3:0]  VARIANT  = 4'h0
) (
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        ce_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire adcri_conv_t conv_in,
    input  wire logic [7:0]  chan_enabled_in,
    input  wire logic        dma_buffer_full_in,
    input  wire logic        dma_receive_end_in,
    input  wire logic [2:0]  timer_output_a_in,
    input  wire logic [2:0]  timer_output_b_in,
    input  wire logic [2:0]  trigger_select_in,
    input  wire logic        ext_trigger_in,
    output logic             trigger_out,
    output logic             irq_out
);

    localparam int CW = $clog2(NCH);

    function automatic logic is_chan(input logic [7:0] a);
        logic [7:0] top;
        top = OFF_CH0 + 8'((NCH - 1) * 4);
        return (a >= OFF_CH0) && (a <= top) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [CW-1:0] chan_of(input logic [7:0] a);
        logic [7:0] d;
        d = a - OFF_CH0;
        return d[CW+1:2];
    endfunction

    // bus address phase
    logic [7:0] a;
    logic       acc;
    logic       rd_acc;
    logic       wr_pend_q;
    logic [7:0] wr_addr_q;
    logic       wr_now;

    assign a      = haddr_in[7:0];
    assign acc    = hsel_in & hready_in & htrans_in[1] & ce_in;
    assign rd_acc = acc & ~hwrite_in;
    assign wr_now = wr_pend_q & ce_in;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (ce_in) begin
            if (hready_in) begin
                wr_pend_q <= acc & hwrite_in;
                wr_addr_q <= a;
            end
        end
    end

    // read side effects
    logic rd_last;
    logic rd_flag;
    logic rd_ch;

    assign rd_last = rd_acc & (a == OFF_LAST);
    assign rd_flag = rd_acc & (a == OFF_FLAG);
    assign rd_ch   = rd_acc & is_chan(a);

    // conversion events
    logic          ev;
    logic [CW-1:0] c;
    logic          c_en;

    assign ev   = conv_in.done & ce_in;
    assign c    = conv_in.chan[CW-1:0];
    assign c_en = chan_enabled_in[c];

    logic [NCH-1:0]    eoc_q;
    logic [NCH-1:0]    ovr_q;
    logic [NCH-1:0]    set_eoc;
    logic [NCH-1:0]    clr_eoc;
    logic [DATA_W-1:0] res_q [NCH];

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            set_eoc[i] = ev & c_en & (c == CW'(i));
            clr_eoc[i] = rd_last |
                         (rd_ch & (chan_of(a) == CW'(i)));
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            eoc_q <= '0;
        end else if (ce_in) begin
            // set wins over read clear
            eoc_q <= set_eoc | (eoc_q & ~clr_eoc);
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ovr_q <= '0;
        end else if (ce_in) begin
            // new result over an unread one
            ovr_q <= (set_eoc & eoc_q & ~clr_eoc) |
                     (ovr_q & ~{NCH{rd_flag}});
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < NCH; i++) begin
                res_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (set_eoc[i]) begin
                    res_q[i] <= conv_in.data;
                end
            end
        end
    end

    // shared last result and data ready
    logic [DATA_W-1:0] last_q;
    logic              result_available_flag_q;
    logic              govr_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            last_q <= '0;
        end else if (ev) begin
            last_q <= conv_in.data;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            result_available_flag_q <= 1'b0;
        end else if (ce_in) begin
            result_available_flag_q <= ev | (result_available_flag_q & ~rd_last);
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            govr_q <= 1'b0;
        end else if (ce_in) begin
            govr_q <= (ev & result_available_flag_q & ~rd_last) |
                      (govr_q & ~rd_flag);
        end
    end

    // dma flags follow their inputs
    logic dma_receive_end_flag_q;
    logic rxbf_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dma_receive_end_flag_q <= FLAG_RST[BIT_DMA_RECEIVE_END_FLAG];
            rxbf_q  <= FLAG_RST[BIT_RXBF];
        end else if (ce_in) begin
            dma_receive_end_flag_q <= dma_receive_end_in;
            rxbf_q  <= dma_buffer_full_in;
        end
    end

    logic [FLAG_W-1:0] flags;
    logic [7:0]        eoc_vis;
    logic [7:0]        ovr_vis;

    always_comb begin
        eoc_vis = '0;
        ovr_vis = '0;
        eoc_vis[NCH-1:0] = eoc_q & chan_enabled_in[NCH-1:0];
        ovr_vis[NCH-1:0] = ovr_q;
        flags = {rxbf_q, dma_receive_end_flag_q, govr_q, result_available_flag_q, ovr_vis, eoc_vis};
    end

    // interrupt mask
    logic [FLAG_W-1:0] mask_q;
    logic [FLAG_W-1:0] mask_d;

    always_comb begin
        mask_d = mask_q;
        if (wr_now && wr_addr_q == OFF_IEN) begin
            mask_d = mask_q | hwdata_in[FLAG_W-1:0];
        end else if (wr_now && wr_addr_q == OFF_IDIS) begin
            mask_d = mask_q & ~hwdata_in[FLAG_W-1:0];
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mask_q <= MASK_RST[FLAG_W-1:0];
        end else if (ce_in) begin
            mask_q <= mask_d;
        end
    end

    logic irq_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_q <= 1'b0;
        end else if (ce_in) begin
            irq_q <= |(flags & mask_q);
        end
    end

    // read data, computed in the address phase
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (a == OFF_FLAG) begin
            rd_mux[FLAG_W-1:0] = flags;
        end else if (a == OFF_LAST) begin
            rd_mux[DATA_W-1:0] = last_q;
        end else if (a == OFF_MASK) begin
            // forward a write still in its data phase
            rd_mux[FLAG_W-1:0] = mask_d;
        end else if (is_chan(a)) begin
            rd_mux[DATA_W-1:0] = res_q[chan_of(a)];
        end else if (a == OFF_REV) begin
            rd_mux[REV_W-1:0] = REVISION;
            rd_mux[VAR_LO+VAR_W-1:VAR_LO] = VARIANT;
        end
    end

    logic [31:0] hrdata_q;
    logic        hready_q;
    logic        hresp_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hrdata_q <= 32'h0000_0000;
        end else if (acc) begin
            hrdata_q <= rd_acc ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hready_q <= 1'b1;
            hresp_q  <= 1'b0;
        end else begin
            hready_q <= 1'b1;
            hresp_q  <= 1'b0;
        end
    end

    // trigger selection
    logic [5:0] trig_vec;
    logic       trig_q;

    assign trig_vec = {timer_output_b_in[2], timer_output_a_in[2],
                       timer_output_b_in[1], timer_output_a_in[1],
                       timer_output_b_in[0], timer_output_a_in[0]};

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            trig_q <= 1'b0;
        end else if (ce_in) begin
            if (trigger_select_in <= TRIG_LAST) begin
                trig_q <= trig_vec[trigger_select_in];
            end else if (trigger_select_in == TRIG_EXT) begin
                trig_q <= ext_trigger_in;
            end else begin
                trig_q <= 1'b0;
            end
        end
    end

    assign hrdata_out    = hrdata_q;
    assign hreadyout_out = hready_q;
    assign hresp_out     = hresp_q;
    assign trigger_out   = trig_q;
    assign irq_out       = irq_q;

    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    a_eoc_set_done: assert property (
        ev && c_en |=> eoc_q[$past(c)])
        else $error("done flag not set");

    a_eoc_rd_clear: assert property (
        rd_last && !ev |=> eoc_q == '0)
        else $error("done flags not cleared by last read");

    a_eoc_gated: assert property (
        rd_flag |=> (hrdata_q[7:0] & ~$past(chan_enabled_in)) == 8'h00)
        else $error("disabled channel shows done");

    a_last_load: assert property (
        ev |=> last_q == $past(conv_in.data))
        else $error("last result not loaded");

    a_last_hold: assert property (
        !ev |=> $stable(last_q))
        else $error("last result changed without event");

    a_mask_set: assert property (
        wr_now && wr_addr_q == OFF_IEN |=>
        (mask_q & $past(hwdata_in[FLAG_W-1:0]))
            == $past(hwdata_in[FLAG_W-1:0]))
        else $error("mask bits not set");

    a_mask_clear: assert property (
        wr_now && wr_addr_q == OFF_IDIS |=>
        (mask_q & $past(hwdata_in[FLAG_W-1:0])) == '0)
        else $error("mask bits not cleared");

    a_mask_read: assert property (
        rd_acc && a == OFF_MASK && !wr_now |=>
        hrdata_q == {12'h000, $past(mask_q)})
        else $error("mask read wrong");

    a_res_disabled: assert property (
        ev && !c_en |=> res_q[$past(c)] == $past(res_q[c]))
        else $error("disabled channel result loaded");

    a_rev_read: assert property (
        rd_acc && a == OFF_REV |=>
        hrdata_q == {12'h000, VARIANT, 4'h0, REVISION})
        else $error("revision read wrong");

    a_govr_set: assert property (
        ev && result_available_flag_q && !rd_last |=> govr_q)
        else $error("general overrun missed");

    a_result_available_flag_set: assert property (
        ev |=> result_available_flag_q)
        else $error("data ready not set");

    a_irq_level: assert property (
        ce_in |=> irq_q == $past(|(flags & mask_q)))
        else $error("interrupt level wrong");

    a_trig_sel: assert property (
        ce_in && trigger_select_in <= TRIG_LAST |=>
        trig_q == $past(trig_vec[trigger_select_in]))
        else $error("trigger mux wrong");

    a_unused_zero: assert property (
        rd_acc |=> hrdata_q[31:FLAG_W] == '0)
        else $error("unused bits nonzero");

    c_overrun: cover property (ev && c_en && eoc_q[c]);
    c_rd_with_ev: cover property (rd_last && ev);
    c_irq_rise: cover property ($rose(irq_q));
    c_mask_write: cover property (wr_now && wr_addr_q == OFF_IEN);

endmodule

// ==== testbench/adcri_core_model.sv ====
// partner: conversion core, one done pulse per conversion
// assumes requests only while busy_out is low, inputs held meanwhile
`timescale 1ns/1ps
module adcri_core_model
    import adcri_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       req_in,
    input  wire logic [2:0] chan_in,
    input  wire logic [9:0] data_in,
    input  wire logic [3:0] lat_in,
    output adcri_conv_t     conv_out,
    output logic            busy_out
);
    logic [3:0] cnt_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            conv_out <= '0;
            busy_out <= 1'b0;
            cnt_q    <= '0;
        end else if (req_in && !busy_out) begin
            busy_out <= 1'b1;
            cnt_q    <= lat_in;
        end else if (busy_out && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (busy_out) begin
            conv_out <= '{done: 1'b1, chan: chan_in, data: data_in};
            busy_out <= 1'b0;
        end else begin
            // result lines stale outside the pulse
            conv_out <= '{done: 1'b0, chan: ~conv_out.chan,
                          data: ~conv_out.data};
        end
    end
endmodule

// ==== testbench/testbench.sv ====
// bench: bus master, reference model and checks for the result block
// assumes a single clock and the core model as conversion source
`timescale 1ns/1ps
module testbench
    import adcri_pkg::*;
;
    // arbitrary revision and variant values
    localparam logic [11:0] REV  = 12'h0A5;
    localparam logic [3:0]  VARI = 4'h3;
    localparam logic [7:0]  REGS [8] = '{OFF_FLAG, OFF_LAST, OFF_MASK,
        OFF_CH0, 8'h4C, OFF_REV, OFF_IEN, 8'h80};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic        sel, wr, ext, dfull, dend, req, ready, resp, trig, irq, busy;
    logic [1:0]  trans;
    logic [31:0] addr, wdata, rdata;
    logic [2:0]  ta, tb, tsel, rch;
    logic [7:0]  en, m_done, m_ovr;
    logic [9:0]  rdat, m_last;
    logic [9:0]  m_res [8];
    logic [3:0]  lat;
    logic [19:0] m_mask;
    logic        m_result_available_flag, m_govr;
    adcri_conv_t conv;
    int          bad_count = 0;
    int          checks_done = 0;
    logic [31:0] lfsr_q = 32'h0000_7F2F;

    adcri_top #(.REVISION(REV), .VARIANT(VARI)) adcri_top_inst (
        .clk_in(clk), .arst_n_in(rst_n), .ce_in(ce), .hsel_in(sel),
        .haddr_in(addr), .htrans_in(trans), .hwrite_in(wr),
        .hsize_in(3'h2), .hwdata_in(wdata), .hready_in(ready),
        .hrdata_out(rdata), .hreadyout_out(ready), .hresp_out(resp),
        .conv_in(conv), .chan_enabled_in(en), .dma_buffer_full_in(dfull),
        .dma_receive_end_in(dend), .timer_output_a_in(ta),
        .timer_output_b_in(tb), .trigger_select_in(tsel),
        .ext_trigger_in(ext), .trigger_out(trig), .irq_out(irq));

    adcri_core_model adcri_core_model_inst (
        .clk_in(clk), .arst_n_in(rst_n), .req_in(req), .chan_in(rch),
        .data_in(rdat), .lat_in(lat), .conv_out(conv), .busy_out(busy));

    initial begin
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0],
                  lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction

    function automatic logic [19:0] flags();
        return {dfull, dend, m_govr, m_result_available_flag, m_ovr, m_done & en};
    endfunction

    task automatic print_verdict();
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic compare(input string what, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ready !== 1'b1 && n < 50);
        if (n >= 50) bad_count++;
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        sel <= 1'b1;
        trans <= 2'b10;
        wr <= w;
        addr <= {24'h0, a};
        wait_ready();
        sel <= 1'b0;
        trans <= 2'b00;
        wdata <= d;
        wait_ready();
        q = rdata;
        compare("response", 32'h0, resp);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        if (a == OFF_IEN) m_mask = m_mask | d[19:0];
        if (a == OFF_IDIS) m_mask = m_mask & ~d[19:0];
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a);
        logic [31:0] q, v;
        logic [7:0]  k;
        v = 32'h0;
        k = (a - OFF_CH0) >> 2;
        if (a == OFF_FLAG) begin
            v = {12'h0, flags()};
            m_ovr = '0;
            m_govr = 1'b0;
        end else if (a == OFF_LAST) begin
            v = {22'h0, m_last};
            m_done = '0;
            m_result_available_flag = 1'b0;
        end else if (a == OFF_MASK) begin
            v = {12'h0, m_mask};
        end else if (a == OFF_REV) begin
            v = {12'h0, VARI, 4'h0, REV};
        end else if (a >= OFF_CH0 && a <= 8'h4C) begin
            v = {22'h0, m_res[k[2:0]]};
            m_done[k[2:0]] = 1'b0;
        end
        bus(1'b0, a, 32'h0, q);
        compare($sformatf("reg %h", a), v, q);
    endtask

    task automatic convert(input logic [2:0] c, input logic [9:0] d,
                           input logic [3:0] l);
        int n;
        while (busy !== 1'b0) @(posedge clk);
        rch <= c;
        rdat <= d;
        lat <= l;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        n = 0;
        while (conv.done !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (n >= 40) bad_count++;
        // a done pulse while the clock enable is low is not taken
        if (ce === 1'b1) begin
            if (m_done[c]) m_ovr[c] = 1'b1;
            if (m_result_available_flag) m_govr = 1'b1;
            m_last = d;
            m_result_available_flag = 1'b1;
            if (en[c]) begin
                m_res[c] = d;
                m_done[c] = 1'b1;
            end
        end
    endtask

    task automatic chk_irq();
        repeat (2) @(posedge clk);
        compare("irq", {31'h0, |(flags() & m_mask)}, irq);
    endtask

    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end

    initial begin
        logic [31:0] r;
        logic [2:0]  c;
        logic        e;
        {sel, wr, ext, dfull, dend, req} = '0;
        trans = 2'b00;
        addr = '0;
        wdata = '0;
        {ta, tb, tsel, rch, lat, rdat, en} = '0;
        {m_done, m_ovr, m_result_available_flag, m_govr, m_mask, m_last} = '0;
        foreach (m_res[i]) m_res[i] = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (REGS[i]) rd(REGS[i]);
        wreg(OFF_LAST, 32'hFFFF_FFFF);
        wreg(OFF_REV, 32'hFFFF_FFFF);
        rd(OFF_LAST);
        rd(OFF_REV);
        wreg(OFF_IEN, 32'hFFFF_FFFF);
        rd(OFF_MASK);
        wreg(OFF_IDIS, 32'h0005_00F0);
        rd(OFF_MASK);
        wreg(OFF_IEN, 32'h0);
        wreg(OFF_IDIS, 32'h0);
        rd(OFF_MASK);
        r = rnd();
        en <= (r[7:0] | 8'h01) & 8'hFD;
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            c = r[2:0];
            dend <= r[25];
            dfull <= r[26];
            convert(c, r[17:8], {2'b00, r[21:20]});
            chk_irq();
            case (r[31:30])
                2'd0: rd(OFF_FLAG);
                2'd1: rd(OFF_LAST);
                2'd2: rd(OFF_CH0 + {3'h0, c, 2'h0});
                default: ;
            endcase
        end
        for (int k = 0; k < 8; k++) rd(OFF_CH0 + 8'(4 * k));
        rd(OFF_FLAG);
        convert(3'h1, 10'h3FF, 4'h0);
        rd(OFF_FLAG);
        rd(OFF_CH0 + 8'h04);
        rd(OFF_LAST);
        convert(3'h0, 10'h155, 4'h0);
        convert(3'h0, 10'h2AA, 4'h0);
        rd(OFF_FLAG);
        rd(OFF_FLAG);
        rd(OFF_CH0);
        wreg(OFF_IDIS, 32'h000F_FFFF);
        convert(3'h0, 10'h0F0, 4'h3);
        chk_irq();
        wreg(OFF_IEN, 32'h0000_0001);
        chk_irq();
        rd(OFF_CH0);
        chk_irq();
        ce <= 1'b0;
        convert(3'h0, 10'h111, 4'h1);
        ce <= 1'b1;
        rd(OFF_LAST);
        rd(OFF_CH0);
        for (int s = 0; s < 8; s++) begin
            r = rnd();
            tsel <= 3'(s);
            ta <= r[2:0];
            tb <= r[5:3];
            ext <= r[6];
            repeat (2) @(posedge clk);
            e = s == 6 ? r[6] : s == 7 ? 1'b0 :
                s[0] ? r[3 + s / 2] : r[s / 2];
            compare("trigger", {31'h0, e}, trig);
        end
        print_verdict();
    end
endmodule
